// File: hw/tpm_pkg.sv
// constants, register map and lookup helpers for the tos priority map
`default_nettype none
package tpm_pkg;
    localparam int          PRIO_W      = 2;
    localparam int          FIELDS      = 8;
    localparam int          MAP_W       = 16;
    localparam int          UPPER_W     = 3 * MAP_W;
    localparam int          LOWER_W     = 80;
    localparam int          CODE_W      = 6;
    localparam int          CODE_LSB    = 2;
    localparam int          ADDR_W      = 8;

    // printed register indices; byte address is four times the index
    localparam logic [7:0]  MAP_A0_BC_IDX  = 8'h0a;
    localparam logic [7:0]  MAP_C0_DC_IDX  = 8'h00;
    localparam logic [7:0]  MAP_E0_FC_IDX  = 8'h02;
    localparam logic [7:0]  PORT_EN_IDX    = 8'h10;
    localparam logic [7:0]  STATUS_IDX     = 8'h11;
    localparam logic [7:0]  MAP_A0_BC_ADDR = MAP_A0_BC_IDX << 2;
    localparam logic [7:0]  MAP_C0_DC_ADDR = MAP_C0_DC_IDX << 2;
    localparam logic [7:0]  MAP_E0_FC_ADDR = MAP_E0_FC_IDX << 2;
    localparam logic [7:0]  PORT_EN_ADDR   = PORT_EN_IDX << 2;
    localparam logic [7:0]  STATUS_ADDR    = STATUS_IDX << 2;

    localparam logic [15:0] MAP_RESET      = 16'h0000;
    localparam logic [1:0]  PRIO_LOWEST    = 2'h0;

    // status register layout
    localparam int          STAT_PRIO_LSB  = 0;
    localparam int          STAT_TOS_BIT   = 2;
    localparam int          STAT_SEEN_BIT  = 3;

    // byte-lane merge of a 16-bit register, lanes 0 and 1 only
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wdata,
                                            input logic [3:0]  strb);
        logic [15:0] res;
        res = old;
        if (strb[0]) begin
            res[7:0] = wdata[7:0];
        end
        if (strb[1]) begin
            res[15:8] = wdata[15:8];
        end
        return res;
    endfunction

    // field for code n (tos bits 7:2) sits at bits 2n+1:2n of the whole table
    function automatic logic [1:0] pick_prio(
        input logic [LOWER_W+UPPER_W-1:0] table_bits,
        input logic [CODE_W-1:0]          code);
        logic [1:0] res;
        res = table_bits[{code, 1'b0} +: PRIO_W];
        return res;
    endfunction
endpackage
`default_nettype wire

// File: hw/tpm_cls_if.sv
// carrier between the register bank and the frame classifier
`timescale 1ns/1ps
`default_nettype none
interface tpm_cls_if;
    logic [tpm_pkg::UPPER_W-1:0] map_upper;
    logic [tpm_pkg::LOWER_W-1:0] map_lower;
    logic                        req_valid;
    logic [7:0]                  req_tos;
    logic                        req_use_tos;
    logic [1:0]                  req_default;
    logic                        resp_valid;
    logic [1:0]                  resp_prio;
    logic                        resp_from_tos;

    modport bank (
        output map_upper, map_lower, req_valid, req_tos, req_use_tos,
               req_default,
        input  resp_valid, resp_prio, resp_from_tos
    );
    modport cls (
        input  map_upper, map_lower, req_valid, req_tos, req_use_tos,
               req_default,
        output resp_valid, resp_prio, resp_from_tos
    );
endinterface
`default_nettype wire

// File: hw/tpm_classifier.sv
// frame priority lookup from the tos byte, one cycle of latency
`timescale 1ns/1ps
`default_nettype none
module tpm_classifier (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // register bank side
    tpm_cls_if.cls    cif
);
    // the two low tos bits never reach the table
    wire logic [tpm_pkg::CODE_W-1:0] code =
        cif.req_tos[7:tpm_pkg::CODE_LSB];
    wire logic [tpm_pkg::LOWER_W+tpm_pkg::UPPER_W-1:0] whole =
        {cif.map_upper, cif.map_lower};
    wire logic [1:0] tos_prio = tpm_pkg::pick_prio(whole, code);
    wire logic [1:0] prio_next =
        cif.req_use_tos ? tos_prio : cif.req_default;

    logic       valid_reg;
    logic [1:0] prio_reg;
    logic       from_tos_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            valid_reg    <= 1'b0;
            prio_reg     <= tpm_pkg::PRIO_LOWEST;
            from_tos_reg <= 1'b0;
        end else begin
            valid_reg <= cif.req_valid;
            if (cif.req_valid) begin
                prio_reg     <= prio_next;
                from_tos_reg <= cif.req_use_tos;
            end
        end
    end

    assign cif.resp_valid    = valid_reg;
    assign cif.resp_prio     = prio_reg;
    assign cif.resp_from_tos = from_tos_reg;
endmodule
`default_nettype wire

// File: hw/tpm_tos_map_upper.sv
// apb register bank for tos code points 0xa0..0xfc plus classifier
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - first register maps 0xa0 low to 0xbc high
// - second register maps 0xc0 low to 0xdc high
// - third register maps 0xe0 low to 0xfc high
// - all fields read/write, reset to lowest priority
// - lookup uses tos bits 7:2 only
// - codes 0x00-0x9c come from companion registers
module tpm_tos_map_upper #(
    parameter int NUM_PORTS = 2,
    parameter int PORT_W    = (NUM_PORTS > 1) ? $clog2(NUM_PORTS) : 1
) (
    // clock and reset
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    // apb slave
    input  wire logic [tpm_pkg::ADDR_W-1:0]  paddr,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [31:0]                 pwdata,
    input  wire logic [3:0]                  pstrb,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    // companion map for code points 0x00..0x9c
    input  wire logic [tpm_pkg::LOWER_W-1:0] lower_map,
    // classifier request
    input  wire logic                        cls_valid,
    input  wire logic [7:0]                  cls_tos,
    input  wire logic [PORT_W-1:0]           cls_port,
    input  wire logic                        cls_is_ip,
    input  wire logic [1:0]                  cls_default_prio,
    // classifier answer
    output logic                             prio_valid,
    output logic      [1:0]                  prio,
    output logic                             prio_from_tos
);
    localparam int EXT = 1 << PORT_W;

    logic [15:0]          map_a0_bc_reg;
    logic [15:0]          map_c0_dc_reg;
    logic [15:0]          map_e0_fc_reg;
    logic [NUM_PORTS-1:0] port_en_reg;
    logic [3:0]           status_reg;
    logic [3:0]           status_next;
    logic [31:0]          prdata_reg;

    tpm_cls_if cif ();

    // address decode
    wire logic hit_a0 = (paddr == tpm_pkg::MAP_A0_BC_ADDR);
    wire logic hit_c0 = (paddr == tpm_pkg::MAP_C0_DC_ADDR);
    wire logic hit_e0 = (paddr == tpm_pkg::MAP_E0_FC_ADDR);
    wire logic hit_pe = (paddr == tpm_pkg::PORT_EN_ADDR);
    wire logic hit_st = (paddr == tpm_pkg::STATUS_ADDR);
    wire logic mapped = hit_a0 | hit_c0 | hit_e0 | hit_pe | hit_st;

    wire logic setup  = psel & ~penable;
    wire logic access = psel & penable;
    wire logic wr_en  = access & pwrite & mapped;

    // read mux; unused upper bits read as zero
    wire logic [31:0] rd_mux =
        hit_a0 ? {16'h0000, map_a0_bc_reg} :
        hit_c0 ? {16'h0000, map_c0_dc_reg} :
        hit_e0 ? {16'h0000, map_e0_fc_reg} :
        hit_pe ? 32'(port_en_reg) :
        hit_st ? {28'h0000000, status_reg} :
                 32'h00000000;

    // zero wait states: the access phase always completes at once
    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;
    assign prdata  = prdata_reg;

    // field n of each register is the code base plus 4n
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            map_a0_bc_reg <= tpm_pkg::MAP_RESET;
            map_c0_dc_reg <= tpm_pkg::MAP_RESET;
            map_e0_fc_reg <= tpm_pkg::MAP_RESET;
        end else if (wr_en) begin
            if (hit_a0) begin
                map_a0_bc_reg <= tpm_pkg::merge16(map_a0_bc_reg,
                                                  pwdata, pstrb);
            end
            if (hit_c0) begin
                map_c0_dc_reg <= tpm_pkg::merge16(map_c0_dc_reg,
                                                  pwdata, pstrb);
            end
            if (hit_e0) begin
                map_e0_fc_reg <= tpm_pkg::merge16(map_e0_fc_reg,
                                                  pwdata, pstrb);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_en_reg <= '0;
        end else if (wr_en && hit_pe && pstrb[0]) begin
            port_en_reg <= pwdata[NUM_PORTS-1:0];
        end
    end

    // read data is captured in the setup cycle, stable through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h00000000;
        end else if (setup && !pwrite) begin
            prdata_reg <= rd_mux;
        end
    end

    // status shows the last answer of the classifier
    always_comb begin
        status_next = status_reg;
        if (cif.resp_valid) begin
            status_next[tpm_pkg::STAT_PRIO_LSB +: 2] = cif.resp_prio;
            status_next[tpm_pkg::STAT_TOS_BIT]       = cif.resp_from_tos;
            status_next[tpm_pkg::STAT_SEEN_BIT]      = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg <= 4'h0;
        end else begin
            status_reg <= status_next;
        end
    end

    // ports beyond NUM_PORTS read as disabled
    wire logic [EXT-1:0] en_ext  = EXT'(port_en_reg);
    wire logic           use_tos = cls_is_ip & en_ext[cls_port];

    assign cif.map_upper   = {map_e0_fc_reg, map_c0_dc_reg,
                              map_a0_bc_reg};
    assign cif.map_lower   = lower_map;
    assign cif.req_valid   = cls_valid;
    assign cif.req_tos     = cls_tos;
    assign cif.req_use_tos = use_tos;
    assign cif.req_default = cls_default_prio;

    tpm_classifier u_cls (
        .pclk    (pclk),
        .presetn (presetn),
        .cif     (cif.cls)
    );

    assign prio_valid    = cif.resp_valid;
    assign prio          = cif.resp_prio;
    assign prio_from_tos = cif.resp_from_tos;
endmodule
`default_nettype wire

// File: test/tpm_tos_map_upper_assertions.sv
// checker for the tos priority map register bank and its lookup
`timescale 1ns/1ps
`default_nettype none
module tpm_tos_map_upper_chk #(
    parameter int NUM_PORTS = 2,
    parameter int PORT_W    = 1
) (
    // clock and reset
    input wire logic                        pclk,
    input wire logic                        presetn,
    // apb
    input wire logic [tpm_pkg::ADDR_W-1:0]  paddr,
    input wire logic                        psel,
    input wire logic                        penable,
    input wire logic                        pwrite,
    input wire logic [31:0]                 pwdata,
    input wire logic [3:0]                  pstrb,
    input wire logic [31:0]                 prdata,
    input wire logic                        pready,
    input wire logic                        pslverr,
    // lookup
    input wire logic [tpm_pkg::LOWER_W-1:0] lower_map,
    input wire logic                        cls_valid,
    input wire logic [7:0]                  cls_tos,
    input wire logic [PORT_W-1:0]           cls_port,
    input wire logic                        cls_is_ip,
    input wire logic [1:0]                  cls_default_prio,
    input wire logic                        prio_valid,
    input wire logic [1:0]                  prio,
    input wire logic                        prio_from_tos
);
    wire logic       acc = psel && penable;
    wire logic       mapped = paddr == tpm_pkg::MAP_A0_BC_ADDR
        || paddr == tpm_pkg::MAP_C0_DC_ADDR || paddr == tpm_pkg::MAP_E0_FC_ADDR
        || paddr == tpm_pkg::PORT_EN_ADDR || paddr == tpm_pkg::STATUS_ADDR;
    // only meaningful below 0xa0, where the index stays inside the vector
    wire logic [1:0] lo_f = lower_map[{cls_tos[7:2], 1'b0} +: 2];

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_answer_next: assert property (cls_valid |=> prio_valid)
        else $error("no answer one cycle after a request");
    a_no_stray: assert property (!cls_valid |=> !prio_valid)
        else $error("answer without a request");
    a_prio_holds: assert property (!prio_valid |-> $stable(prio)
        && $stable(prio_from_tos)) else $error("priority moved without answer");
    a_not_ip_default: assert property (cls_valid && !cls_is_ip |=>
        prio == $past(cls_default_prio) && !prio_from_tos)
        else $error("non ip frame not given default priority");
    a_lower_codes: assert property (cls_valid && cls_tos < 8'ha0 |=>
        !prio_from_tos || prio == $past(lo_f))
        else $error("low code point not taken from companion map");
    a_pready_access: assert property (acc |-> pready)
        else $error("access phase without ready");
    a_err_unmapped: assert property (acc |-> pslverr == !mapped)
        else $error("error flag does not match address decode");
    a_read_width: assert property (acc && !pwrite |->
        prdata[31:16] == 16'h0 && (mapped || prdata == 32'h0))
        else $error("read data outside register width");

    c_tos_hit: cover property (cls_valid && cls_is_ip ##1 prio_from_tos);
    c_unmapped: cover property (acc && !mapped);
    c_map_write: cover property (acc && pwrite && mapped);
endmodule

bind tpm_tos_map_upper tpm_tos_map_upper_chk #(
    .NUM_PORTS(NUM_PORTS), .PORT_W(PORT_W)
) u_chk (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .lower_map, .cls_valid, .cls_tos, .cls_port,
    .cls_is_ip, .cls_default_prio, .prio_valid, .prio, .prio_from_tos);
`default_nettype wire

// File: test/tb_tpm_tos_map_upper.sv
// self-checking bench for the tos priority map register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
    $display("Error at %0t: got %h expected %h", $time, a, b); end end
module tb_tpm_tos_map_upper;
    // distinct field values so a misplaced field shows
    localparam logic [15:0] R0  = 16'he4e4;
    localparam logic [15:0] R1  = 16'h1b1b;
    localparam logic [15:0] R2  = 16'h72d8;
    localparam logic [79:0] LOW = {5{16'h9c63}};
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic        cls_valid, cls_is_ip, prio_valid, prio_from_tos;
    logic [7:0]  paddr, cls_tos;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic [1:0]  cls_default_prio, prio;
    logic [0:0]  cls_port;
    logic [47:0] tbl;
    logic [7:0]  ad [3];
    logic [15:0] pat [3];
    int          err_count, compares, cyc;

    tpm_tos_map_upper #(.NUM_PORTS(2)) u_dut (.pclk(pclk), .presetn(presetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .lower_map(LOW), .cls_valid(cls_valid),
        .cls_tos(cls_tos), .cls_port(cls_port), .cls_is_ip(cls_is_ip),
        .cls_default_prio(cls_default_prio), .prio_valid(prio_valid),
        .prio(prio), .prio_from_tos(prio_from_tos));

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    task test_done();
        if (err_count == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            test_done();
        end
    end

    // entered just after a rising edge; leaves one idle cycle behind
    task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task look(input logic [7:0] t, input logic ip, input logic pt,
              input logic [1:0] dp, input logic [1:0] ep, input logic ef);
        cls_valid <= 1'b1;
        cls_tos <= t;
        cls_is_ip <= ip;
        cls_port <= pt;
        cls_default_prio <= dp;
        @(posedge pclk);
        cls_valid <= 1'b0;
        #1;
        `CHK({prio_valid, prio, prio_from_tos}, {1'b1, ep, ef})
        @(posedge pclk);
    endtask

    initial begin
        {psel, penable, pwrite, cls_valid, cls_is_ip, presetn} = '0;
        {paddr, cls_tos, pwdata, cls_default_prio, cls_port} = '0;
        pstrb = 4'hf;
        ad = '{tpm_pkg::MAP_A0_BC_ADDR, tpm_pkg::MAP_C0_DC_ADDR,
               tpm_pkg::MAP_E0_FC_ADDR};
        pat = '{R0, R1, R2};
        tbl = {R2, R1, R0};
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 3; i++) begin
            apb(ad[i], 1'b0, 32'h0);
            `CHK(rd, 32'h0)
            apb(ad[i], 1'b1, {16'hffff, pat[i]});
        end
        for (int i = 0; i < 3; i++) begin
            apb(ad[i], 1'b0, 32'h0);
            `CHK({er, rd}, {17'h0, pat[i]})
        end
        apb(8'h0c, 1'b1, 32'hffff);
        `CHK(er, 1'b1)
        apb(8'h0c, 1'b0, 32'h0);
        `CHK({er, rd}, 33'h100000000)
        apb(tpm_pkg::PORT_EN_ADDR, 1'b1, 32'h1);
        // every upper code with all four low-bit patterns
        for (int c = 8'ha0; c <= 8'hff; c++) begin
            look(c[7:0], 1'b1, 1'b0, 2'h3, tbl[(c / 4 - 40) * 2 +: 2], 1'b1);
        end
        look(8'h9f, 1'b1, 1'b0, 2'h1, LOW[79:78], 1'b1);
        look(8'hbc, 1'b0, 1'b0, 2'h2, 2'h2, 1'b0);
        look(8'hbc, 1'b1, 1'b1, 2'h1, 2'h1, 1'b0);
        // status keeps the last answer: seen, not from map, priority 1
        apb(tpm_pkg::STATUS_ADDR, 1'b0, 32'h0);
        `CHK({er, rd}, 33'h9)
        apb(tpm_pkg::PORT_EN_ADDR, 1'b0, 32'h0);
        `CHK({er, rd}, 33'h1)
        // only lane 1 written, lane 0 must keep its old field values
        pstrb <= 4'h2;
        apb(ad[0], 1'b1, 32'h0);
        pstrb <= 4'hf;
        apb(ad[0], 1'b0, 32'h0);
        `CHK({er, rd}, {17'h0, 8'h00, R0[7:0]})
        // second reset in mid-run returns fields and enables to zero
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(ad[0], 1'b0, 32'h0);
        `CHK({er, rd}, 33'h0)
        look(8'hfc, 1'b1, 1'b0, 2'h2, 2'h2, 1'b0);
        test_done();
    end
endmodule
`default_nettype wire
